// ### logic/pwio_port.v
// Notes on behaviour
// R1: Sixteen-bit output word, writable and readable, drives the output lines.
// R2: Any word or byte write of output word fires one new-data strobe.
// R3: User should capture outputs on the new-data strobe falling edge.
// R4: Bus initialize clears the output word to zero.
// R5: Input word is unlatched; input lines gated straight onto read data. Here they pass a two-flop synchroniser first.
// R6: User must hold input lines stable until the processor reads them.
// R7: Every input word read fires one data-taken strobe pulse.
// R8: Data-taken strobe falls only after the read data was captured.
// R9: Request B reads as status bit 15, request A as bit 7.
// R10: Interrupt requested for A with enable bit 6, B with bit 5.
// R11: Both enable bits are read and write by the processor.
// R12: User sets its request flip-flop when it needs service.
// R13: User clears its request flip-flop on a strobe trailing edge.
// R14: User set pulse ends before the clearing strobe trailing edge.
// R15: User may end its set pulse on a strobe leading edge.
// R16: Set pulses under ten microseconds are usually adequate.
// R17: Bus initialize clears enables, command bits, interrupt and acknowledge state.
// R18: Strobe widths come from internal counters with parameter lengths.
`timescale 1ns/1ps
`include "pwio_defines.vh"
module pwio_port #(
   parameter NEWDATA_CYC = `PWIO_NEWDATA_CYC,
   parameter TAKEN_CYC = `PWIO_TAKEN_CYC
) (
   // Clock and resets
   input wire clk_sys,
   input wire rstn,
   input wire busInitializeN,
   // Register port
   input wire [1:0] regSel,
   input wire regWrite,
   input wire regRead,
   input wire [1:0] byteEn,
   input wire [15:0] writeData,
   output reg [15:0] readData,
   output reg readValid,
   // Interrupt handshake
   input wire irqAck,
   output reg irqRequest,
   output reg irqSourceB,
   // User side
   output reg [15:0] outLines,
   output reg newDataStrobe,
   input wire [15:0] inLines,
   output reg inputTakenStrobe,
   output reg userCommandBitZero,
   output reg userCommandBitOne,
   input wire requestA,
   input wire requestB,
   output reg initToUser
);
   // Pin synchronisers
   reg [15:0] inMeta;
   reg [15:0] inSync;
   // Request flags reach the status word two cycles late
   reg reqAMeta;
   reg reqASync;
   reg reqBMeta;
   reg reqBSync;
   reg initMeta;
   reg initSync;
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         inMeta <= 16'h0000;
         inSync <= 16'h0000;
         reqAMeta <= 1'b0;
         reqASync <= 1'b0;
         reqBMeta <= 1'b0;
         reqBSync <= 1'b0;
         initMeta <= 1'b1;
         initSync <= 1'b1;
      end else begin
         inMeta <= inLines;
         inSync <= inMeta;
         reqAMeta <= requestA;
         reqASync <= reqAMeta;
         reqBMeta <= requestB;
         reqBSync <= reqBMeta;
         initMeta <= busInitializeN;
         initSync <= initMeta;
      end
   end
   // Initialize also cuts a running strobe short
   wire init = ~initSync;

   wire [15:0] outputWord;
   reg ienA;
   reg ienB;
   reg cmd0;
   reg cmd1;
   wire wrOut = regWrite && (regSel == `PWIO_SEL_OUT);
   wire wrCsr = regWrite && (regSel == `PWIO_SEL_CSR);
   wire rdIn = regRead && (regSel == `PWIO_SEL_IN);

   // One lane per byte, so a byte cycle leaves the other half untouched
   genvar lane;
   generate
      for (lane = 0; lane < `PWIO_LANES; lane = lane + 1) begin : gLane
         reg [`PWIO_BYTE_W-1:0] laneWord;
         always @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               laneWord <= `PWIO_ZERO8;
            end else if (init) begin
               laneWord <= `PWIO_ZERO8; // R4
            end else if (wrOut && byteEn[lane]) begin
               laneWord <= writeData[lane*`PWIO_BYTE_W +: `PWIO_BYTE_W]; // R1
            end
         end
         assign outputWord[lane*`PWIO_BYTE_W +: `PWIO_BYTE_W] = laneWord;
      end
   endgenerate

   // Control bits sit in the low byte; a high-byte-only cycle changes nothing
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ienA <= 1'b0;
         ienB <= 1'b0;
         cmd0 <= 1'b0;
         cmd1 <= 1'b0;
      end else if (init) begin
         ienA <= 1'b0; // R17
         ienB <= 1'b0;
         cmd0 <= 1'b0;
         cmd1 <= 1'b0;
      end else begin
         if (wrCsr && byteEn[0]) begin
            ienA <= writeData[`PWIO_BIT_IENA]; // R11
            ienB <= writeData[`PWIO_BIT_IENB];
            cmd0 <= writeData[`PWIO_BIT_CMD0];
            cmd1 <= writeData[`PWIO_BIT_CMD1];
         end
      end
   end

   // Read path; input word passes the pin synchronisers every cycle and is captured into readData at the read
   reg [15:0] csrWord;
   always @* begin
      csrWord = `PWIO_ZERO16;
      csrWord[`PWIO_BIT_REQB] = reqBSync; // R9
      csrWord[`PWIO_BIT_REQA] = reqASync;
      csrWord[`PWIO_BIT_IENA] = ienA;
      csrWord[`PWIO_BIT_IENB] = ienB;
      csrWord[`PWIO_BIT_CMD1] = cmd1;
      csrWord[`PWIO_BIT_CMD0] = cmd0;
   end
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         readData <= `PWIO_ZERO16;
         readValid <= 1'b0;
      end else begin
         readValid <= regRead;
         if (regRead) begin
            case (regSel)
               `PWIO_SEL_CSR: readData <= csrWord;
               `PWIO_SEL_OUT: readData <= outputWord;
               `PWIO_SEL_IN: readData <= inSync; // R5
               default: readData <= `PWIO_ZERO16;
            endcase
         end
      end
   end

   // Strobes; any write strobe to the output word with at least one byte enable set fires new-data
   wire ndPulse;
   wire itPulse;
   pwio_pulse_gen #(.LEN(NEWDATA_CYC)) uNewData (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .clear(init),
      .fire(wrOut && (byteEn != 2'h0)), // R2 R18
      .pulse(ndPulse)
   );
   // Fired at the read, so the trailing edge always follows the capture
   pwio_pulse_gen #(.LEN(TAKEN_CYC)) uTaken (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .clear(init),
      .fire(rdIn), // R7 R8 R18
      .pulse(itPulse)
   );

   // Interrupt request and acknowledge; A has priority
   reg ackSeen;
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         irqRequest <= 1'b0;
         irqSourceB <= 1'b0;
         ackSeen <= 1'b0;
      end else if (init) begin
         irqRequest <= 1'b0; // R17
         irqSourceB <= 1'b0;
         ackSeen <= 1'b0;
      end else if (irqAck) begin
         irqRequest <= 1'b0;
         ackSeen <= 1'b1;
      end else begin
         // Level request; re-raised while the flag is still asserted
         ackSeen <= 1'b0;
         irqRequest <= !ackSeen && ((reqASync && ienA) || (reqBSync && ienB)); // R10
         irqSourceB <= !(reqASync && ienA);
      end
   end

   // Output registers toward the user
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         outLines <= `PWIO_ZERO16;
         newDataStrobe <= 1'b0;
         inputTakenStrobe <= 1'b0;
         userCommandBitZero <= 1'b0;
         userCommandBitOne <= 1'b0;
         initToUser <= 1'b0;
      end else begin
         outLines <= outputWord; // R1
         newDataStrobe <= ndPulse; // R2
         inputTakenStrobe <= itPulse; // R7
         userCommandBitZero <= cmd0;
         userCommandBitOne <= cmd1;
         initToUser <= init;
      end
   end
endmodule

// ### logic/pwio_defines.vh
`ifndef PWIO_DEFINES_VH
`define PWIO_DEFINES_VH
// Register selects (word index on the local register port)
`define PWIO_SEL_CSR 2'h0
`define PWIO_SEL_OUT 2'h1
`define PWIO_SEL_IN 2'h2
// Control and status word fields
`define PWIO_BIT_REQB 15
`define PWIO_BIT_REQA 7
`define PWIO_BIT_IENA 6
`define PWIO_BIT_IENB 5
`define PWIO_BIT_CMD1 1
`define PWIO_BIT_CMD0 0
`define PWIO_ZERO16 16'h0000
`define PWIO_ZERO8 8'h00
// Output word byte lanes
`define PWIO_LANES 2
`define PWIO_BYTE_W 8
// Strobe lengths in cycles of clk_sys
`define PWIO_NEWDATA_CYC 70
`define PWIO_TAKEN_CYC 230
`endif

// ### logic/pwio_pulse_gen.v
`timescale 1ns/1ps
module pwio_pulse_gen #(
   parameter LEN = 8
) (
   // Clock and reset
   input wire clk_sys,
   input wire rstn,
   // Control
   input wire clear,
   input wire fire,
   output reg pulse
);
   reg [15:0] count;
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         count <= 16'h0000;
         pulse <= 1'b0;
      end else if (clear) begin
         count <= 16'h0000;
         pulse <= 1'b0;
      end else if (fire) begin
         // A new fire restarts the full width
         count <= LEN[15:0];
         pulse <= 1'b1;
      end else if (count != 16'h0000) begin
         count <= count - 16'h0001;
         pulse <= (count != 16'h0001);
      end
   end
endmodule

// ### bench/pwio_chk_properties.sv
`timescale 1ns/1ps
module pwio_chk #(
   parameter NEWDATA_CYC = 4
) (
   // Watched ports
   input wire clk_sys, rstn, busInitializeN, regWrite, regRead, readValid,
   input wire newDataStrobe, inputTakenStrobe, irqRequest, requestA, requestB,
   input wire [1:0] regSel, byteEn,
   input wire [15:0] writeData, readData, outLines
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_newdata_rise: assert property (regWrite && regSel == 2'h1 && byteEn != 2'h0
      |-> ##2 newDataStrobe) else $error("no new-data strobe");
   a_taken_rise: assert property (regRead && regSel == 2'h2 |-> ##2 inputTakenStrobe)
      else $error("no taken strobe");
   a_taken_late: assert property ($rose(inputTakenStrobe) |-> $past(readValid))
      else $error("taken strobe before data");
   a_strobe_width: assert property ($fell(newDataStrobe)
      |-> $past(newDataStrobe, NEWDATA_CYC)) else $error("strobe too short");
   a_out_follow: assert property (regWrite && regSel == 2'h1 && byteEn == 2'h3
      |-> ##2 outLines == $past(writeData, 2)) else $error("output lines wrong");
   a_csr_zero: assert property (regRead && regSel == 2'h0
      |=> readData[14:8] == 7'h00 && readData[4:2] == 3'h0) else $error("reserved set");
   a_irq_cause: assert property ($rose(irqRequest)
      |-> $past(requestA, 3) || $past(requestB, 3)) else $error("irq without request");
   a_init_clear: assert property (!busInitializeN [*4]
      |-> ##2 outLines == 16'h0000 && !irqRequest) else $error("init left state");
endmodule
bind pwio_port pwio_chk #(.NEWDATA_CYC(NEWDATA_CYC)) u_chk (.*);

// ### bench/pwio_user_dev.sv
`timescale 1ns/1ps
module pwio_user_dev (
   // Strobes and lines from the port
   input wire rstn, newDataStrobe, inputTakenStrobe,
   input wire [15:0] outLines,
   // Set pulses
   input wire setA, setB,
   // Requests and captured word
   output reg requestA, requestB,
   output reg [15:0] capWord
);
   // Trailing edge lets cable data settle
   always @(negedge newDataStrobe or negedge rstn) capWord <= rstn ? outLines : 16'h0000;
   always @(posedge setA or negedge newDataStrobe or negedge rstn) requestA <= rstn & setA;
   always @(posedge setB or negedge inputTakenStrobe or negedge rstn) requestB <= rstn & setB;
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
   reg clk_sys = 0, rstn = 0, busInitializeN = 1, regWrite = 0, regRead = 0, setA = 0, setB = 0;
   reg irqAck = 0;
   reg [1:0] regSel = 0, byteEn = 0;
   reg [15:0] writeData = 0, inLines = 0, got;
   wire [15:0] readData, outLines, capWord;
   wire readValid, newDataStrobe, inputTakenStrobe, irqRequest, irqSourceB;
   wire requestA, requestB, userCommandBitZero, userCommandBitOne, initToUser;
   integer errors = 0, samples_checked = 0, n, nNew = 0, nTaken = 0;
   always #2.5 clk_sys = !clk_sys;
   always @(posedge newDataStrobe) nNew = nNew + 1;
   always @(posedge inputTakenStrobe) nTaken = nTaken + 1;
   pwio_port #(.NEWDATA_CYC(4), .TAKEN_CYC(4)) DUT (.clk_sys, .rstn, .busInitializeN,
      .regSel, .regWrite, .regRead, .byteEn, .writeData, .readData, .readValid,
      .irqAck, .irqRequest, .irqSourceB, .outLines, .newDataStrobe, .inLines,
      .inputTakenStrobe, .userCommandBitZero, .userCommandBitOne, .requestA, .requestB,
      .initToUser);
   pwio_user_dev U (.rstn, .newDataStrobe, .inputTakenStrobe, .outLines, .setA, .setB,
      .requestA, .requestB, .capWord);
   task cyc(input integer k); repeat (k) @(negedge clk_sys); endtask
   task stop_test; begin
      $display("errors %0d checks %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   end endtask
   task chk(input [15:0] e, input [15:0] a); begin
      samples_checked = samples_checked + 1;
      if (a !== e) begin
         errors = errors + 1;
         $display("wrong value at %0t: %h not %h", $time, a, e);
      end
   end endtask
   task wr(input [1:0] s, input [1:0] b, input [15:0] d); begin
      cyc(1); regSel = s; byteEn = b; writeData = d; regWrite = 1;
      cyc(1); regWrite = 0;
   end endtask
   task rd(input [1:0] s); begin
      cyc(1); regSel = s; regRead = 1;
      cyc(1); regRead = 0; n = 0;
      while (!readValid && n < 4) begin cyc(1); n = n + 1; end
      if (n == 4) begin errors = errors + 1; stop_test; end
      got = readData;
   end endtask
   // Short set pulse, gone long before any strobe trailing edge
   task pulse(input b); begin cyc(1); if (b) setB = 1; else setA = 1; cyc(1); setA = 0; setB = 0; end endtask
   task t_out; begin
      wr(2'h1, 2'h3, 16'hA5C3); cyc(10);
      chk(16'hA5C3, outLines);
      chk(16'hA5C3, capWord);
      wr(2'h1, 2'h2, 16'h7E00); rd(2'h1); chk(16'h7EC3, got);
      cyc(6); wr(2'h1, 2'h1, 16'hFF11); rd(2'h1); chk(16'h7E11, got);
      wr(2'h2, 2'h3, 16'hFFFF); cyc(10); chk(3, nNew);
      chk(16'h7E11, capWord);
   end endtask
   task t_in; begin
      inLines = 16'h1234; cyc(3); rd(2'h2);
      chk(16'h1234, got);
      cyc(10); chk(1, nTaken);
   end endtask
   task t_req; begin
      pulse(0); cyc(6); rd(2'h0); chk(16'h0080, got);
      wr(2'h0, 2'h1, 16'h0043); cyc(6); chk(1, irqRequest);
      chk(0, irqSourceB);
      irqAck = 1; cyc(1); irqAck = 0; chk(0, irqRequest);
      cyc(2); chk(1, irqRequest);
      rd(2'h0); chk(16'h00C3, got);
      chk(3, {userCommandBitOne, userCommandBitZero});
      wr(2'h1, 2'h3, 16'h0000); cyc(14); chk(0, irqRequest);
      wr(2'h0, 2'h1, 16'h0020); pulse(1); cyc(6); chk(1, irqRequest);
      chk(16'h8000, {irqSourceB, 15'h0000});
      rd(2'h0); chk(16'h8020, got);
      rd(2'h2); cyc(14); chk(0, irqRequest);
   end endtask
   task t_init; begin
      wr(2'h1, 2'h3, 16'hFFFF); cyc(12); pulse(0);
      wr(2'h0, 2'h1, 16'h0063); cyc(6); chk(1, irqRequest);
      busInitializeN = 0; cyc(6); chk(1, initToUser);
      busInitializeN = 1; cyc(3); chk(0, initToUser);
      chk(16'h0000, outLines);
      chk(0, irqRequest);
      rd(2'h0); chk(16'h0080, got);
      rd(2'h3); chk(16'h0000, got);
   end endtask
   initial begin
      cyc(16); rstn = 1;
      t_out; t_in; t_req; t_init;
      stop_test;
   end
endmodule
